// ### rtl/bit_matrix_transpose_negate.sv
// Column-to-row gather, row-to-column scatter and 16-bit negate datapath.
`timescale 1ns/1ns

// Operation
// - Condition off: no operation, no word written.
// - Column-to-row puts bit C of source word S+k into destination bit k.
// - Column-to-row raises error for a non-decimal or out-of-range selector.
// - Column-to-row sets zero flag exactly when the destination is zero.
// - Row-to-column writes bit k of S into bit C of word D+k.
// - Row-to-column raises error for a non-decimal or out-of-range selector.
// - Row-to-column sets zero flag exactly when the source is zero.
// - Negate writes the 16-bit two's complement of the source.
// - Negate of zero gives zero and sets zero flag; else clears it.
// - Negate of 8000 gives 8000 and sets underflow; else clears it.
// - Indirect pointer fault raises the error flag for every operation.
module bit_matrix_transpose_negate (
	// Clock and reset.
	input wire logic CORE_CLK_I,
	input wire logic SRST_I,
	// Instruction request from the sequencer.
	input wire logic EXEC_I,
	input wire logic [1:0] OP_I,
	input wire logic COND_I,
	input wire logic EDGE_ONLY_I,
	input wire logic [15:0] SRC_WORD_I,
	input wire logic [15:0] SEL_I,
	input wire logic PTR_FAULT_I,
	// Access to the sixteen-word set.
	output logic MEM_RD_O,
	output logic MEM_WR_O,
	output logic [3:0] MEM_IDX_O,
	output logic [15:0] MEM_WDATA_O,
	input wire logic [15:0] MEM_RDATA_I,
	// Result word and flags.
	output logic BUSY_O,
	output logic DONE_O,
	output logic RESULT_WR_O,
	output logic [15:0] RESULT_O,
	output logic INSTRUCTION_ERROR_FLAG_O,
	output logic ZERO_RESULT_FLAG_O,
	output logic UNDERFLOW_FLAG_O
);

	typedef enum logic [2:0] {IDLE, READ, CAPTURE, WRITE, FINISH} state_t;

	state_t state_reg, state_next;
	logic [3:0] k_reg, k_next;
	logic [1:0] op_reg;
	logic run_reg;
	logic fault_reg;
	logic [3:0] col_reg;
	logic [15:0] src_reg;
	logic [15:0] acc_reg;
	logic [15:0] wdata_reg;
	logic [15:0] result_reg;
	logic rwr_reg;
	logic done_reg;
	logic er_reg;
	logic eq_reg;
	logic uf_reg;
	logic [3:0] prev_reg;

	// Selector decode: two decimal digits, upper byte zero, value 00 to 15.
	wire sel_digits_ok = (SEL_I[15:8] == bmt_pkg::SEL_HIGH_ZERO) && (SEL_I[7:4] <= bmt_pkg::SEL_TENS_MAX)
		&& (SEL_I[3:0] <= bmt_pkg::SEL_ONES_MAX);
	wire sel_range_ok = !((SEL_I[7:4] == bmt_pkg::SEL_TENS_MAX) && (SEL_I[3:0] > bmt_pkg::SEL_ONES_TOP));
	wire sel_ok = sel_digits_ok && sel_range_ok;
	wire [3:0] sel_bin = (SEL_I[7:4] != 4'h0) ? 4'(SEL_I[3:0] + bmt_pkg::SEL_TEN) : SEL_I[3:0];

	// Request qualification; the prefixed form needs an off-to-on change.
	wire accept = EXEC_I && (state_reg == IDLE);
	wire op_known = (OP_I != bmt_pkg::OP_RESERVED);
	wire go = COND_I && op_known && !(EDGE_ONLY_I && prev_reg[OP_I]);
	wire needs_sel = (OP_I != bmt_pkg::OP_NEGATE);
	wire fault = PTR_FAULT_I || (needs_sel && !sel_ok);
	wire walk = go && !fault && needs_sel;

	// Bit picked from the returned word, and the bit to be scattered.
	wire cap_bit = MEM_RDATA_I[col_reg];
	wire src_bit = src_reg[k_reg];
	wire is_row = (op_reg == bmt_pkg::OP_ROW_TO_COL);
	wire at_last = (k_reg == bmt_pkg::SET_LAST);
	wire [15:0] neg_word = 16'(bmt_pkg::WORD_ZERO - src_reg);
	wire finish_ok = (state_reg == FINISH) && run_reg && !fault_reg;

	// Read-modify-write word: only bit C is replaced by the source bit.
	wire [15:0] merged;
	genvar g;
	generate
		for (g = 0; g < bmt_pkg::WORD_W; g = g + 1) begin : g_merge
			assign merged[g] = (col_reg == 4'(g)) ? src_bit : MEM_RDATA_I[g];
		end
	endgenerate

	// Sequencer: one read per word, plus a write back when scattering.
	always_comb begin
		state_next = state_reg;
		k_next = k_reg;
		case (state_reg)
			IDLE: begin
				if (accept) begin
					state_next = walk ? READ : FINISH;
					k_next = bmt_pkg::IDX_FIRST;
				end
			end
			READ: begin
				state_next = CAPTURE;
			end
			CAPTURE: begin
				if (is_row) begin
					state_next = WRITE;
				end else begin
					state_next = at_last ? FINISH : READ;
					k_next = 4'(k_reg + 4'h1);
				end
			end
			WRITE: begin
				state_next = at_last ? FINISH : READ;
				k_next = 4'(k_reg + 4'h1);
			end
			FINISH: begin
				state_next = IDLE;
			end
			default: begin
				state_next = IDLE;
			end
		endcase
	end

	// State, index and request capture.
	always_ff @(posedge CORE_CLK_I) begin
		if (SRST_I) begin
			state_reg <= IDLE;
			k_reg <= bmt_pkg::IDX_FIRST;
			op_reg <= bmt_pkg::OP_COL_TO_ROW;
			run_reg <= 1'b0;
			fault_reg <= 1'b0;
			col_reg <= 4'h0;
			src_reg <= bmt_pkg::WORD_ZERO;
			prev_reg <= 4'h0;
		end else begin
			state_reg <= state_next;
			k_reg <= k_next;
			if (accept) begin
				op_reg <= OP_I;
				run_reg <= go;
				fault_reg <= fault;
				col_reg <= sel_bin;
				src_reg <= SRC_WORD_I;
				prev_reg[OP_I] <= COND_I;
			end
		end
	end

	// Gathered word and the write-back word.
	always_ff @(posedge CORE_CLK_I) begin
		if (SRST_I) begin
			acc_reg <= bmt_pkg::WORD_ZERO;
			wdata_reg <= bmt_pkg::WORD_ZERO;
		end else if (state_reg == CAPTURE) begin
			if (is_row) begin
				wdata_reg <= merged;
			end else begin
				acc_reg[k_reg] <= cap_bit;
			end
		end
	end

	// Completion: flags and result change only on an executed instruction.
	always_ff @(posedge CORE_CLK_I) begin
		if (SRST_I) begin
			result_reg <= bmt_pkg::WORD_ZERO;
			rwr_reg <= 1'b0;
			done_reg <= 1'b0;
			er_reg <= 1'b0;
			eq_reg <= 1'b0;
			uf_reg <= 1'b0;
		end else begin
			done_reg <= (state_reg == FINISH);
			rwr_reg <= finish_ok && !is_row;
			if ((state_reg == FINISH) && run_reg) begin
				er_reg <= fault_reg;
			end
			if (finish_ok) begin
				case (op_reg)
					bmt_pkg::OP_COL_TO_ROW: begin
						result_reg <= acc_reg;
						eq_reg <= (acc_reg == bmt_pkg::WORD_ZERO);
					end
					bmt_pkg::OP_ROW_TO_COL: begin
						eq_reg <= (src_reg == bmt_pkg::WORD_ZERO);
					end
					default: begin
						result_reg <= neg_word;
						eq_reg <= (src_reg == bmt_pkg::WORD_ZERO);
						uf_reg <= (src_reg == bmt_pkg::WORD_MIN_NEG);
					end
				endcase
			end
		end
	end

	// Strobes follow the state; index and data come from flip-flops.
	assign MEM_RD_O = (state_reg == READ);
	assign MEM_WR_O = (state_reg == WRITE);
	assign MEM_IDX_O = k_reg;
	assign MEM_WDATA_O = wdata_reg;
	assign BUSY_O = (state_reg != IDLE);
	assign DONE_O = done_reg;
	assign RESULT_WR_O = rwr_reg;
	assign RESULT_O = result_reg;
	assign INSTRUCTION_ERROR_FLAG_O = er_reg;
	assign ZERO_RESULT_FLAG_O = eq_reg;
	assign UNDERFLOW_FLAG_O = uf_reg;

	// Checks on the datapath.
	default clocking cb @(posedge CORE_CLK_I); endclocking
	default disable iff (SRST_I);

	a_skip_no_write: assert property (
		accept && !COND_I |=> !MEM_RD_O && !MEM_WR_O ##1 DONE_O && !RESULT_WR_O)
		else $error("Skipped instruction touched a word.");

	a_col_sel_error: assert property (
		accept && go && OP_I == bmt_pkg::OP_COL_TO_ROW && !sel_ok |-> ##2 DONE_O && INSTRUCTION_ERROR_FLAG_O)
		else $error("Bad gather selector did not raise error.");

	a_row_sel_error: assert property (
		accept && go && OP_I == bmt_pkg::OP_ROW_TO_COL && !sel_ok |-> ##2 DONE_O && INSTRUCTION_ERROR_FLAG_O)
		else $error("Bad scatter selector did not raise error.");

	a_ptr_fault_error: assert property (
		accept && go && PTR_FAULT_I |-> ##2 INSTRUCTION_ERROR_FLAG_O && !RESULT_WR_O)
		else $error("Pointer fault did not raise error.");

	a_fault_no_write: assert property (
		accept && go && fault |-> ##1 (!MEM_WR_O && !RESULT_WR_O) [*2])
		else $error("Faulted instruction wrote a word.");

	a_edge_only_once: assert property (
		accept && EDGE_ONLY_I && prev_reg[OP_I] |-> ##2 DONE_O && !RESULT_WR_O && !$past(MEM_WR_O))
		else $error("Prefixed instruction ran without a rising condition.");

	a_gather_bit: assert property (
		state_reg == CAPTURE && !is_row |=> acc_reg[$past(k_reg)] == $past(cap_bit))
		else $error("Gathered bit landed in the wrong place.");

	a_scatter_bit: assert property (
		state_reg == CAPTURE && is_row |=> MEM_WR_O && MEM_WDATA_O[col_reg] == $past(src_bit))
		else $error("Scattered bit not written to column.");

	a_gather_zero: assert property (
		finish_ok && !is_row && op_reg == bmt_pkg::OP_COL_TO_ROW
		|=> RESULT_WR_O && ZERO_RESULT_FLAG_O == (RESULT_O == bmt_pkg::WORD_ZERO))
		else $error("Gather zero flag disagrees with result.");

	a_scatter_zero: assert property (
		finish_ok && is_row |=> ZERO_RESULT_FLAG_O == ($past(src_reg) == bmt_pkg::WORD_ZERO))
		else $error("Scatter zero flag disagrees with source.");

	a_negate_value: assert property (
		finish_ok && op_reg == bmt_pkg::OP_NEGATE |=> RESULT_WR_O && 16'(RESULT_O + $past(src_reg)) == 16'h0000)
		else $error("Negate result is not the complement.");

	a_negate_zero: assert property (
		finish_ok && op_reg == bmt_pkg::OP_NEGATE
		|=> ZERO_RESULT_FLAG_O == (RESULT_O == bmt_pkg::WORD_ZERO))
		else $error("Negate zero flag wrong.");

	a_negate_under: assert property (
		finish_ok && op_reg == bmt_pkg::OP_NEGATE
		|=> UNDERFLOW_FLAG_O == (RESULT_O == bmt_pkg::WORD_MIN_NEG))
		else $error("Negate underflow flag wrong.");

	// Transfer lengths are fixed, so a lost or extra word shows up as a late or early done pulse.
	a_gather_length: assert property (
		accept && walk && OP_I == bmt_pkg::OP_COL_TO_ROW |-> ##34 DONE_O && RESULT_WR_O)
		else $error("Gather did not finish after sixteen reads.");

	a_scatter_length: assert property (
		accept && walk && OP_I == bmt_pkg::OP_ROW_TO_COL |-> ##50 DONE_O && !RESULT_WR_O)
		else $error("Scatter did not finish after sixteen writes.");

	a_write_same_word: assert property (
		MEM_WR_O |-> $past(MEM_RD_O, 2) && MEM_IDX_O == $past(MEM_IDX_O, 2))
		else $error("Write back went to a word that was not read.");

	a_reserved_no_op: assert property (
		accept && OP_I == bmt_pkg::OP_RESERVED |-> ##2 DONE_O && !RESULT_WR_O && $stable(INSTRUCTION_ERROR_FLAG_O))
		else $error("Reserved code changed a flag or wrote a word.");

	a_under_negate_only: assert property (
		finish_ok && op_reg != bmt_pkg::OP_NEGATE |=> $stable(UNDERFLOW_FLAG_O))
		else $error("Underflow flag moved outside a negate.");

	a_fault_keeps_words: assert property (
		accept && go && fault |-> ##2 $stable(RESULT_O) && $stable(ZERO_RESULT_FLAG_O))
		else $error("Faulted instruction changed result or zero flag.");

endmodule // bit_matrix_transpose_negate

// ### rtl/bmt_pkg.sv
// Shared constants for the bit matrix transpose and negate datapath.
package bmt_pkg;
	localparam int WORD_W = 16;
	localparam int IDX_W = 4;
	// Operation codes carried on OP_I.
	localparam logic [1:0] OP_COL_TO_ROW = 2'h0;
	localparam logic [1:0] OP_ROW_TO_COL = 2'h1;
	localparam logic [1:0] OP_NEGATE = 2'h2;
	localparam logic [1:0] OP_RESERVED = 2'h3;
	// Word set geometry.
	localparam logic [3:0] SET_LAST = 4'hF;
	localparam logic [3:0] IDX_FIRST = 4'h0;
	// Decimal column selector limits.
	localparam logic [7:0] SEL_HIGH_ZERO = 8'h00;
	localparam logic [3:0] SEL_TENS_MAX = 4'h1;
	localparam logic [3:0] SEL_ONES_MAX = 4'h9;
	localparam logic [3:0] SEL_ONES_TOP = 4'h5;
	localparam logic [3:0] SEL_TEN = 4'hA;
	// Word values with special meaning.
	localparam logic [15:0] WORD_ZERO = 16'h0000;
	localparam logic [15:0] WORD_MIN_NEG = 16'h8000;
endpackage

// ### rtl/bmt_dummy_none.sv
// Holds no logic; the datapath and its constants live in their own files.

// ### tb/test_bit_matrix_transpose_negate.sv
// Self-checking testbench for the transpose and negate datapath.
`timescale 1ns/1ns
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin bad_count++; $display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (b)); end end
module test_bit_matrix_transpose_negate;
	logic clk = 1'b0;
	logic srst = 1'b1;
	logic exec = 1'b0;
	logic cond = 1'b0;
	logic edge_only = 1'b0;
	logic fault = 1'b0;
	logic [1:0] op = 2'h0;
	logic [15:0] src = 16'h0000;
	logic [15:0] sel = 16'h0000;
	logic [15:0] rdata = 16'h0000;
	logic rd, wr, busy, done, res_wr, err, zero, uf, seen_wr, z0;
	logic [3:0] idx;
	logic [15:0] wdata, result, r0, x;
	logic [15:0] mem [16];
	logic [15:0] old [16];
	int bad_count = 0;
	int checked = 0;
	int rd_n = 0;
	int n0;
	// Rows of negate cases: source, result, zero, underflow.
	logic [33:0] rows [5] = '{{16'h0000, 16'h0000, 2'b10}, {16'h8000, 16'h8000, 2'b01},
		{16'h0001, 16'hFFFF, 2'b00}, {16'h001F, 16'hFFE1, 2'b00}, {16'hFFFF, 16'h0001, 2'b00}};
	logic [15:0] bad_sel [3] = '{16'h0016, 16'h001A, 16'h0100};

	bit_matrix_transpose_negate bit_matrix_transpose_negate_i (.CORE_CLK_I(clk), .SRST_I(srst), .EXEC_I(exec),
		.OP_I(op), .COND_I(cond), .EDGE_ONLY_I(edge_only), .SRC_WORD_I(src), .SEL_I(sel), .PTR_FAULT_I(fault),
		.MEM_RD_O(rd), .MEM_WR_O(wr), .MEM_IDX_O(idx), .MEM_WDATA_O(wdata), .MEM_RDATA_I(rdata), .BUSY_O(busy),
		.DONE_O(done), .RESULT_WR_O(res_wr), .RESULT_O(result), .INSTRUCTION_ERROR_FLAG_O(err),
		.ZERO_RESULT_FLAG_O(zero), .UNDERFLOW_FLAG_O(uf));

	// Clock at 50 MHz.
	always #10 clk = ~clk;

	// Word set with one-cycle read latency; the data line toggles between reads so stale data never passes.
	always @(posedge clk) begin
		if (wr) mem[idx] <= wdata;
		if (rd) begin
			rdata <= mem[idx];
			rd_n <= rd_n + 1;
		end else rdata <= ~rdata;
	end

	// Column of the word set as the gather should deliver it.
	function automatic logic [15:0] gather(input int c);
		logic [15:0] g;
		for (int k = 0; k < 16; k++) g[k] = mem[k][c];
		return g;
	endfunction

	// One request, then a bounded wait for completion; the write strobe is caught in the done cycle.
	task automatic run(input logic [1:0] o, input logic c, e, f, input logic [15:0] s, l);
		@(posedge clk);
		op <= o;
		cond <= c;
		edge_only <= e;
		fault <= f;
		src <= s;
		sel <= l;
		exec <= 1'b1;
		@(posedge clk);
		exec <= 1'b0;
		for (int n = 0; n < 60 && done !== 1'b1; n++) @(negedge clk);
		`CHK(done, 1'b1)
		seen_wr = res_wr;
	endtask

	// Prints the counts and the verdict, then ends the run.
	task automatic summarize();
		$display("checks %0d mismatches %0d", checked, bad_count);
		if (bad_count == 0 && checked > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask

	// Watchdog sized well above the few hundred cycles the sequence needs.
	initial begin
		repeat (6000) @(posedge clk);
		bad_count++;
		summarize();
	end

	// Main sequence: row loop first, then the awkward cases by hand.
	initial begin
		for (int k = 0; k < 16; k++) mem[k] = 16'h9A6B ^ (16'h0F31 * 16'(k));
		repeat (16) @(posedge clk);
		srst <= 1'b0;
		@(negedge clk);
		`CHK({busy, done, res_wr, err, zero, uf, result}, 22'h000000)
		for (int i = 0; i < 5; i++) begin
			run(bmt_pkg::OP_NEGATE, 1'b1, 1'b0, 1'b0, rows[i][33:18], 16'h0000);
			`CHK({seen_wr, result}, {1'b1, rows[i][17:2]})
			`CHK({zero, uf, err}, {rows[i][1:0], 1'b0})
		end
		// A zero source scattered into column 3 makes that column all zero for the gather after it.
		run(bmt_pkg::OP_ROW_TO_COL, 1'b1, 1'b0, 1'b0, 16'h0000, 16'h0003);
		`CHK({zero, seen_wr}, 2'b10)
		run(bmt_pkg::OP_COL_TO_ROW, 1'b1, 1'b0, 1'b0, 16'h0000, 16'h0003);
		`CHK({result, zero, seen_wr}, 18'h00003)
		n0 = rd_n;
		run(bmt_pkg::OP_COL_TO_ROW, 1'b1, 1'b0, 1'b0, 16'h0000, 16'h0015);
		`CHK({result, zero}, {gather(15), 1'b0})
		`CHK(rd_n - n0, 16)
		// Decimal 10 must not be read as sixteen.
		run(bmt_pkg::OP_COL_TO_ROW, 1'b1, 1'b0, 1'b0, 16'h0000, 16'h0010);
		`CHK(result, gather(10))
		old = mem;
		run(bmt_pkg::OP_ROW_TO_COL, 1'b1, 1'b0, 1'b0, 16'hC35A, 16'h0012);
		`CHK({zero, seen_wr}, 2'b00)
		for (int k = 0; k < 16; k++) begin
			x = old[k];
			x[12] = k[3:0] inside {4'h1, 4'h3, 4'h4, 4'h6, 4'h8, 4'h9, 4'hE, 4'hF};
			`CHK(mem[k], x)
		end
		// Bad selectors: flag raised, word set untouched, result and zero flag kept.
		for (int j = 0; j < 6; j++) begin
			n0 = rd_n;
			r0 = result;
			z0 = zero;
			run((j < 3) ? bmt_pkg::OP_COL_TO_ROW : bmt_pkg::OP_ROW_TO_COL, 1'b1, 1'b0, 1'b0, 16'h1234, bad_sel[j % 3]);
			`CHK({err, seen_wr, rd_n == n0, zero, result}, {3'b101, z0, r0})
		end
		run(bmt_pkg::OP_NEGATE, 1'b1, 1'b0, 1'b1, 16'h8000, 16'h0000);
		`CHK({err, seen_wr, uf, result}, {3'b100, r0})
		n0 = rd_n;
		run(bmt_pkg::OP_COL_TO_ROW, 1'b1, 1'b0, 1'b1, 16'h0000, 16'h0005);
		`CHK({err, seen_wr, rd_n == n0}, 3'b101)
		run(bmt_pkg::OP_ROW_TO_COL, 1'b1, 1'b0, 1'b1, 16'hFFFF, 16'h0003);
		`CHK({err, seen_wr, rd_n == n0, zero}, {3'b101, z0})
		// Condition off changes nothing, the error flag included.
		run(bmt_pkg::OP_NEGATE, 1'b0, 1'b0, 1'b0, 16'h0001, 16'h0000);
		`CHK({err, seen_wr, result}, {2'b10, r0})
		run(bmt_pkg::OP_NEGATE, 1'b1, 1'b1, 1'b0, 16'h0002, 16'h0000);
		`CHK({err, seen_wr, result}, {2'b01, 16'hFFFE})
		run(bmt_pkg::OP_NEGATE, 1'b1, 1'b1, 1'b0, 16'h0003, 16'h0000);
		`CHK({seen_wr, result}, {1'b0, 16'hFFFE})
		run(bmt_pkg::OP_RESERVED, 1'b1, 1'b0, 1'b0, 16'h0004, 16'h0000);
		`CHK({seen_wr, result}, {1'b0, 16'hFFFE})
		// A reset in the middle of a gather clears flags, result, index, write data and the prefixed history.
		run(bmt_pkg::OP_NEGATE, 1'b1, 1'b0, 1'b0, 16'h8000, 16'h0000);
		`CHK({seen_wr, uf, result}, {2'b11, 16'h8000})
		@(posedge clk);
		op <= bmt_pkg::OP_COL_TO_ROW;
		sel <= 16'h0005;
		exec <= 1'b1;
		@(posedge clk);
		exec <= 1'b0;
		repeat (4) @(posedge clk);
		srst <= 1'b1;
		@(posedge clk);
		srst <= 1'b0;
		@(negedge clk);
		`CHK({busy, rd, wr, idx, wdata, err, zero, uf, result}, 42'h0)
		run(bmt_pkg::OP_NEGATE, 1'b1, 1'b1, 1'b0, 16'h0005, 16'h0000);
		`CHK({seen_wr, uf, result}, {2'b10, 16'hFFFB})
		summarize();
	end
endmodule // test_bit_matrix_transpose_negate
